// ### bench/parallel_flash_config_master_tb.sv
/* Bench: registers, chained load, user pins, boot modes, program request.
   Assumes the flash model and bound checker. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module parallel_flash_config_master_tb;
    import pfcm_pkg::*;
    logic clk_i = 0, link_clk = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
    logic por_ok = 0, prog_n = 1, pud = 0, ext_low = 0, slow = 0;
    logic init_oe, init_o, init_w, pin_drive, pullup_en, cfg_valid, done, config_clock, config_clock_q;
    logic chain_n, sclk_q;
    logic [7:0] adr = 8'h00, fdata, cfg_data;
    logic [31:0] dat = 32'h0, rdat, q, spi_sh;
    logic [2:0] mode = BOOT_PAR_UP;
    pfcm_flash_t flash;
    pfcm_spi_t spi;
    int n_mismatch = 0, num_checks = 0, n_byte = 0, n_chain = 0, ticks = 0;
    assign init_w = !(init_oe || ext_low);
    pfcm_top #(.INIT_CYCLES_P(20)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .por_ok_i(por_ok), .program_request_n_i(prog_n),
        .pullup_disable_i(pud), .boot_mode_i(mode), .link_clk_i(link_clk),
        .flash_data_i(fdata), .init_status_n_i(init_w), .init_status_n_o(init_o),
        .init_status_oe_o(init_oe), .flash_o(flash), .spi_o(spi),
        .chain_select_out_n_o(chain_n), .config_clock_o(config_clock), .pin_drive_o(pin_drive),
        .pullup_en_o(pullup_en), .cfg_data_o(cfg_data), .cfg_valid_o(cfg_valid),
        .config_done_o(done));
    pfcm_flash_model flash_part (.link_clk_i(link_clk), .slow_i(slow),
        .pin_drive_i(pin_drive), .flash_i(flash), .data_o(fdata));
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // serial part accepts commands once selected
    always @(posedge link_clk) begin
        sclk_q <= spi.sclk;
        config_clock_q <= config_clock;
        if (!spi.cs_n && spi.sclk && !sclk_q) spi_sh <= {spi_sh[30:0], spi.mosi};
        if (cfg_valid) begin
            `CHK("cfg byte", n_byte[7:0] ^ 8'ha5, cfg_data)
            n_byte++;
        end
        // chained parts take bytes on rising config_clock
        if (config_clock && !config_clock_q && !chain_n) n_chain++;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        r = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask
    task automatic wdone(input logic v);
        int n;
        n = 0;
        while (done !== v && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        `CHK("done", v, done)
    endtask
    task automatic t_regs();
        logic [7:0] a[4] = '{REG_OWN_LEN, REG_CHAIN_LEN, REG_START_ADDR, 8'h20};
        logic [23:0] e[4] = '{OWN_LEN_RST, CHAIN_LEN_RST, START_ADDR_RST, 24'h0};
        for (int i = 0; i < 4; i++) begin
            wb(0, a[i], 0, q);
            `CHK("reg reset", {8'h00, e[i]}, q)
        end
        wb(1, REG_OWN_LEN, 32'h4, q);
        wb(1, REG_CHAIN_LEN, 32'h3, q);
        // offset image keeps test reloads clear
        wb(1, REG_START_ADDR, 32'h2000, q);
        idle(30);
        `CHK("select unpowered", 1'b1, spi.cs_n)
    endtask
    task automatic t_load();
        ext_low <= 1;
        por_ok <= 1;
        idle(60);
        `CHK("select init low", 1'b1, spi.cs_n)
        `CHK("init level", 1'b0, init_o)
        ext_low <= 0;
        wdone(1);
        `CHK("read frame", {SPI_READ_CMD, 24'h002000}, spi_sh)
        `CHK("own bytes", 4, n_byte)
        `CHK("chain bytes", 3, n_chain)
        wb(1, REG_OWN_LEN, 32'h9, q);
        wb(0, REG_OWN_LEN, 0, q);
        `CHK("len locked", 32'h4, q)
        wb(0, REG_STATUS, 0, q);
        `CHK("loaded", 1'b1, q[ST_LOADED_BIT])
    endtask
    task automatic t_user();
        wb(1, REG_CTRL, 32'h6, q);
        idle(4);
        `CHK("x16 select", 1'b1, flash.width_sel)
        `CHK("user a0", 1'b1, flash.addr[0])
    endtask
    task automatic t_modes();
        logic [2:0] m[3] = '{BOOT_PAR_DOWN, BOOT_SLAVE_PAR, BOOT_TEST_PORT};
        int e[3] = '{4, 0, 0};
        int c[3] = '{3, 0, 0};
        for (int i = 0; i < 3; i++) begin
            mode <= m[i];
            slow <= (i == 0);
            n_byte = 0;
            n_chain = 0;
            idle(4);
            wb(1, REG_CTRL, 32'h1, q);
            wdone(0);
            wdone(1);
            `CHK("own bytes", e[i], n_byte)
            `CHK("chain bytes", c[i], n_chain)
        end
        mode <= BOOT_PAR_UP;
        slow <= 0;
    endtask
    // last reload cleared x16: byte mode
    task automatic t_prog();
        for (int i = 0; i < 2; i++) begin
            pud <= (i == 0);
            idle(2);
            prog_n <= 0;
            idle(6);
            `CHK("pins driven", 1'b0, pin_drive)
            `CHK("pull-ups", (i == 1), pullup_en)
            wb(0, REG_STATUS, 0, q);
            `CHK("program low", 1'b1, q[ST_PROG_LOW_BIT])
            n_byte = 0;
            prog_n <= 1;
            wdone(1);
            `CHK("own bytes", 4, n_byte)
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_regs();
        t_load();
        t_user();
        t_modes();
        t_prog();
        finish_test();
    end
endmodule
`default_nettype wire

// ### bench/pfcm_asserts.sv
/* Port checks of the flash configuration master.
   Assumes binding to pfcm_top; slow levels also sampled on clk_i. */
`timescale 1ns/10ps
`default_nettype none
module pfcm_asserts
    import pfcm_pkg::*;
#(
    parameter int INIT_CYCLES_P = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic por_ok_i,
    input wire logic program_request_n_i,
    input wire logic pullup_disable_i,
    input wire logic [2:0] boot_mode_i,
    input wire logic link_clk_i,
    input wire logic init_status_n_i,
    input wire logic init_status_oe_o,
    input wire pfcm_pkg::pfcm_flash_t flash_o,
    input wire pfcm_pkg::pfcm_spi_t spi_o,
    input wire logic chain_select_out_n_o,
    input wire logic config_clock_o,
    input wire logic pin_drive_o,
    input wire logic pullup_en_o,
    input wire logic cfg_valid_o,
    input wire logic config_done_o
);
    int init_cnt;
    // control access restarts the count: stricter only
    always_ff @(posedge clk_i) begin
        if (rst_i || !por_ok_i || !program_request_n_i ||
            (wb_cyc_i && wb_stb_i && wb_adr_i == REG_CTRL)) begin
            init_cnt <= 0;
        end else if (init_cnt < INIT_CYCLES_P) begin
            init_cnt <= init_cnt + 1;
        end
    end
    AST_INIT_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(spi_o.cs_n) |-> init_cnt >= INIT_CYCLES_P) else $error("select too early");
    AST_RELEASE_FIRST: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $fell(spi_o.cs_n) |-> !init_status_oe_o && init_status_n_i) else $error("init held");
    AST_BYTE_WIDE: assert property (@(posedge link_clk_i) disable iff (rst_i)
        !config_done_o && !flash_o.ce_n |-> !flash_o.width_sel) else $error("x16 in load");
    AST_READ_CTRL: assert property (@(posedge link_clk_i) disable iff (rst_i)
        cfg_valid_o |-> !flash_o.ce_n && !flash_o.oe_n && flash_o.we) else $error("strobes");
    AST_ADDR_STEP: assert property (@(posedge link_clk_i) disable iff (rst_i)
        !flash_o.ce_n && !$past(flash_o.ce_n) && !config_done_o && $changed(flash_o.addr)
        |-> flash_o.addr == $past(flash_o.addr) + 24'h1) else $error("address skipped");
    AST_CONFIG_CLOCK_HOLD: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $rose(config_clock_o) |-> $stable(flash_o.addr) && !flash_o.ce_n) else $error("config_clock");
    AST_CHAIN_QUIET: assert property (@(posedge link_clk_i) disable iff (rst_i)
        !chain_select_out_n_o |-> !cfg_valid_o) else $error("own byte in chain");
    AST_NO_FLASH: assert property (@(posedge link_clk_i) disable iff (rst_i)
        (boot_mode_i == BOOT_SLAVE_PAR || boot_mode_i == BOOT_TEST_PORT) && !config_done_o
        |-> flash_o.ce_n) else $error("flash read in slave mode");
    AST_TRISTATE: assert property (@(posedge link_clk_i) disable iff (rst_i)
        !program_request_n_i [*5] |-> !pin_drive_o && pullup_en_o == !pullup_disable_i)
        else $error("pins driven in program");
    cover property (@(posedge link_clk_i) $fell(chain_select_out_n_o));
    cover property (@(posedge link_clk_i) $rose(config_done_o));
    cover property (@(posedge clk_i) $fell(program_request_n_i));
endmodule
bind pfcm_top pfcm_asserts #(.INIT_CYCLES_P(INIT_CYCLES_P)) u_asserts (.*);
`default_nettype wire

// ### bench/pfcm_flash_model.sv
/* Byte-wide parallel flash: each byte is its address low byte xor a5.
   Assumes undriven controls float high, deselecting the part. */
`timescale 1ns/10ps
`default_nettype none
module pfcm_flash_model
    import pfcm_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic slow_i,
    input wire logic pin_drive_i,
    input wire pfcm_pkg::pfcm_flash_t flash_i,
    output logic [7:0] data_o
);
    logic [7:0] stage;
    initial data_o = 8'h3c;
    // width select low keeps byte mode; dual pin is the byte address
    always @(posedge link_clk_i) begin
        stage <= flash_i.addr[7:0] ^ 8'ha5;
        if (!(pin_drive_i && !flash_i.ce_n && !flash_i.oe_n)) begin
            data_o <= ~data_o;
        end else begin
            data_o <= slow_i ? stage : flash_i.addr[7:0] ^ 8'ha5;
        end
    end
endmodule
`default_nettype wire

// ### core/pfcm_spi_cmd.sv
/*
  Serial flash command shifter: one frame, msb first, half-rate clock.
  Assumes start_i is a one-cycle pulse while idle.
*/
`timescale 1ns/10ps
`default_nettype none
module pfcm_spi_cmd
    import pfcm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [31:0] frame_i,
    output pfcm_pkg::pfcm_spi_t spi_o,
    output logic done_o
);
    logic [31:0] frame_reg;
    logic [5:0] bit_cnt_reg;
    logic cs_n_reg;
    logic sclk_reg;
    logic done_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_reg <= '0;
            bit_cnt_reg <= '0;
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start_i && cs_n_reg) begin
                frame_reg <= frame_i;
                bit_cnt_reg <= SPI_FRAME_BITS;
                cs_n_reg <= 1'b0;
            end else if (!cs_n_reg) begin
                // data changes on the falling edge, the flash samples on the rising
                if (!sclk_reg) begin
                    sclk_reg <= 1'b1;
                end else begin
                    sclk_reg <= 1'b0;
                    frame_reg <= {frame_reg[30:0], 1'b0};
                    bit_cnt_reg <= bit_cnt_reg - 6'h01;
                    if (bit_cnt_reg == 6'h01) begin
                        cs_n_reg <= 1'b1;
                        done_reg <= 1'b1;
                    end
                end
            end
        end
    end

    assign spi_o = '{cs_n: cs_n_reg, sclk: sclk_reg, mosi: frame_reg[31]};
    assign done_o = done_reg;
endmodule
`default_nettype wire

// ### core/pfcm_sync.sv
/*
  Two flip-flop level synchroniser.
  Assumes levels or long-held buses; no word coherence.
*/
`timescale 1ns/10ps
`default_nettype none
module pfcm_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d_i;
            q_reg <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule
`default_nettype wire

// ### core/pfcm_top.sv
/*
  Flash configuration master: init timer and registers on clk_i,
  flash sequencer and pins on link_clk_i.
  Assumes pins are synchronised before use and lengths
  stay untouched during a load.
*/
// Overview of operation
// - no configuration starts until all three supplies report power good.
// - about one millisecond of memory clearing follows reset before any access.
// - after clearing, release init, then select serial flash and send read.
// - configuration reads the parallel flash byte-wide only; x16 allowed afterwards.
// - width select held low while configuring; user may drive high afterwards.
// - active-low output enable, active-low chip select and write enable to flash.
// - lowest address bit is byte address, bits 23 to 1 word, data 7..0.
// - lowest address output becomes a user pin after configuration.
// - chain master uses parallel boot code, downstream devices slave parallel code.
// - after own image, keep addressing and pull chain select low for next.
// - downstream devices capture flash data on the driven configuration clock.
// - test port reconfiguration works in any boot mode; a test-port code exists.
// - program request low tri-states all pins; pull-ups on unless disabled.
`timescale 1ns/10ps
`default_nettype none
module pfcm_top #(
    parameter int INIT_CYCLES_P = pfcm_pkg::INIT_CYCLES,
    parameter logic [3:0] READ_WAIT = pfcm_pkg::READ_WAIT_RST
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic por_ok_i,
    input wire logic program_request_n_i,
    input wire logic pullup_disable_i,
    input wire logic [2:0] boot_mode_i,
    input wire logic link_clk_i,
    input wire logic [7:0] flash_data_i,
    input wire logic init_status_n_i,
    output logic init_status_n_o,
    output logic init_status_oe_o,
    output pfcm_pkg::pfcm_flash_t flash_o,
    output pfcm_pkg::pfcm_spi_t spi_o,
    output logic chain_select_out_n_o,
    output logic config_clock_o,
    output logic pin_drive_o,
    output logic pullup_en_o,
    output logic [7:0] cfg_data_o,
    output logic cfg_valid_o,
    output logic config_done_o
);
    import pfcm_pkg::*;

    function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_par_master(input logic [2:0] mode);
        return (mode == BOOT_PAR_UP) || (mode == BOOT_PAR_DOWN);
    endfunction

    function automatic logic is_no_load(input logic [2:0] mode);
        return (mode == BOOT_SLAVE_PAR) || (mode == BOOT_TEST_PORT);
    endfunction

    // system domain
    logic por_ok_s;
    logic prog_n_s;
    logic busy_s;
    logic done_s;
    logic chain_s;
    logic [31:0] init_cnt_reg;
    logic init_done_reg;
    logic reload_reg;
    logic x16_reg;
    logic user_a0_reg;
    logic [23:0] own_len_reg;
    logic [23:0] chain_len_reg;
    logic [23:0] start_addr_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic wb_req;
    logic wb_wr;
    logic len_lock;
    logic [31:0] status_word;

    // link domain
    logic link_rst;
    logic lprog_n_s;
    logic lpull_dis_s;
    logic linit_s;
    logic [2:0] lboot_s;
    logic [7:0] ldata_s;
    logic lrun_s;
    logic lx16_s;
    logic la0_s;
    pfcm_link_state_t state_reg;
    logic [2:0] mode_reg;
    logic [23:0] addr_reg;
    logic [23:0] remain_reg;
    logic [23:0] chain_cnt_reg;
    logic [3:0] wait_reg;
    logic chain_phase_reg;
    logic chain_sel_n_reg;
    logic config_clock_reg;
    logic ce_n_reg;
    logic oe_n_reg;
    logic init_drive_reg;
    logic spi_start_reg;
    logic spi_done;
    logic [7:0] cfg_data_reg;
    logic cfg_valid_reg;
    logic busy_l_reg;
    logic done_l_reg;
    pfcm_flash_t flash_reg;
    logic pin_drive_reg;
    logic pullup_en_reg;

    pfcm_sync #(.W(5)) u_sync_sys (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({por_ok_i, program_request_n_i, busy_l_reg, done_l_reg, chain_phase_reg}),
        .q_o({por_ok_s, prog_n_s, busy_s, done_s, chain_s})
    );

    // reset crosses as a level; this stage has none
    pfcm_sync #(.W(1)) u_sync_rst (
        .clk_i(link_clk_i),
        .rst_i(1'b0),
        .d_i(rst_i),
        .q_o(link_rst)
    );

    // flash data is read only after READ_WAIT cycles of a stable address
    pfcm_sync #(.W(17)) u_sync_link (
        .clk_i(link_clk_i),
        .rst_i(link_rst),
        .d_i({program_request_n_i, pullup_disable_i, init_status_n_i, boot_mode_i,
              flash_data_i, init_done_reg, x16_reg, user_a0_reg}),
        .q_o({lprog_n_s, lpull_dis_s, linit_s, lboot_s, ldata_s, lrun_s, lx16_s, la0_s})
    );

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr = wb_req && wb_we_i;
    assign len_lock = init_done_reg || busy_s;

    // clearing timer; restarts on supply loss, program request or reload
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            init_cnt_reg <= '0;
            init_done_reg <= 1'b0;
        end else if (!por_ok_s || !prog_n_s || reload_reg) begin
            init_cnt_reg <= '0;
            init_done_reg <= 1'b0;
        end else if (init_cnt_reg == 32'(INIT_CYCLES_P - 1)) begin
            init_done_reg <= 1'b1;
        end else begin
            init_cnt_reg <= init_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_reg <= 1'b0;
            x16_reg <= 1'b0;
            user_a0_reg <= 1'b0;
        end else begin
            reload_reg <= 1'b0;
            if (wb_wr && (wb_adr_i == REG_CTRL) && wb_sel_i[0]) begin
                // a reload behaves like a short program request pulse
                reload_reg <= wb_dat_i[CTRL_RELOAD_BIT];
                x16_reg <= wb_dat_i[CTRL_X16_BIT];
                user_a0_reg <= wb_dat_i[CTRL_USER_A0_BIT];
            end
        end
    end

    // lengths cross as held words, locked during a load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            own_len_reg <= OWN_LEN_RST;
            chain_len_reg <= CHAIN_LEN_RST;
            start_addr_reg <= START_ADDR_RST;
        end else if (wb_wr && !len_lock) begin
            unique case (wb_adr_i)
                REG_OWN_LEN: own_len_reg <= 24'(wb_merge({8'h00, own_len_reg}, wb_dat_i,
                                                         wb_sel_i));
                REG_CHAIN_LEN: chain_len_reg <= 24'(wb_merge({8'h00, chain_len_reg}, wb_dat_i,
                                                             wb_sel_i));
                // a nonzero start leaves room below the image for test reloads
                REG_START_ADDR: start_addr_reg <= 24'(wb_merge({8'h00, start_addr_reg}, wb_dat_i,
                                                               wb_sel_i));
                default: ;
            endcase
        end
    end

    always_comb begin
        status_word = '0;
        status_word[ST_INIT_DONE_BIT] = init_done_reg;
        status_word[ST_BUSY_BIT] = busy_s;
        status_word[ST_LOADED_BIT] = done_s;
        status_word[ST_CHAIN_BIT] = chain_s;
        status_word[ST_PROG_LOW_BIT] = !prog_n_s;
        status_word[ST_POR_OK_BIT] = por_ok_s;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= wb_req;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    REG_CTRL: rdata_reg <= {29'h0, user_a0_reg, x16_reg, 1'b0};
                    REG_OWN_LEN: rdata_reg <= {8'h00, own_len_reg};
                    REG_CHAIN_LEN: rdata_reg <= {8'h00, chain_len_reg};
                    REG_STATUS: rdata_reg <= status_word;
                    REG_START_ADDR: rdata_reg <= {8'h00, start_addr_reg};
                    default: rdata_reg <= '0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    pfcm_spi_cmd u_spi (
        .clk_i(link_clk_i),
        .rst_i(link_rst),
        .start_i(spi_start_reg),
        .frame_i({SPI_READ_CMD, start_addr_reg}),
        .spi_o(spi_o),
        .done_o(spi_done)
    );

    // losing run returns the sequencer to idle
    always_ff @(posedge link_clk_i) begin
        if (link_rst || !lrun_s) begin
            state_reg <= L_IDLE;
            mode_reg <= '0;
            addr_reg <= '0;
            remain_reg <= '0;
            chain_cnt_reg <= '0;
            wait_reg <= '0;
            chain_phase_reg <= 1'b0;
            chain_sel_n_reg <= 1'b1;
            config_clock_reg <= 1'b0;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            init_drive_reg <= 1'b1;
            spi_start_reg <= 1'b0;
            cfg_data_reg <= '0;
            cfg_valid_reg <= 1'b0;
        end else begin
            spi_start_reg <= 1'b0;
            cfg_valid_reg <= 1'b0;
            unique case (state_reg)
                L_IDLE: begin
                    // straps are taken as init is released
                    mode_reg <= lboot_s;
                    addr_reg <= start_addr_reg;
                    remain_reg <= own_len_reg;
                    chain_cnt_reg <= chain_len_reg;
                    init_drive_reg <= 1'b0;
                    state_reg <= L_RELEASE;
                end
                L_RELEASE: begin
                    // an external hold on init delays the load
                    if (linit_s) begin
                        if (is_no_load(mode_reg)) begin
                            state_reg <= L_DONE;
                        end else begin
                            spi_start_reg <= 1'b1;
                            state_reg <= L_SPI;
                        end
                    end
                end
                L_SPI: begin
                    if (spi_done) begin
                        if (is_par_master(mode_reg) && (remain_reg != 24'h0)) begin
                            ce_n_reg <= 1'b0;
                            oe_n_reg <= 1'b0;
                            wait_reg <= '0;
                            state_reg <= L_READ;
                        end else begin
                            state_reg <= L_DONE;
                        end
                    end
                end
                L_READ: begin
                    if (wait_reg == READ_WAIT - 4'h1) begin
                        cfg_data_reg <= ldata_s;
                        cfg_valid_reg <= !chain_phase_reg;
                        config_clock_reg <= 1'b1;
                        state_reg <= L_CLK;
                    end else begin
                        wait_reg <= wait_reg + 4'h1;
                    end
                end
                L_CLK: begin
                    config_clock_reg <= 1'b0;
                    addr_reg <= addr_reg + 24'h1;
                    remain_reg <= remain_reg - 24'h1;
                    wait_reg <= '0;
                    state_reg <= L_READ;
                    if (remain_reg == 24'h1) begin
                        if (!chain_phase_reg && (chain_cnt_reg != 24'h0)) begin
                            chain_phase_reg <= 1'b1;
                            chain_sel_n_reg <= 1'b0;
                            remain_reg <= chain_cnt_reg;
                        end else begin
                            ce_n_reg <= 1'b1;
                            oe_n_reg <= 1'b1;
                            chain_sel_n_reg <= 1'b1;
                            state_reg <= L_DONE;
                        end
                    end
                end
                L_DONE: ;
            endcase
        end
    end

    // pins from flops; after load width select and address bit 0 go to the user
    always_ff @(posedge link_clk_i) begin
        if (link_rst) begin
            flash_reg <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we: 1'b1, width_sel: 1'b0};
            pin_drive_reg <= 1'b0;
            pullup_en_reg <= 1'b0;
            busy_l_reg <= 1'b0;
            done_l_reg <= 1'b0;
        end else begin
            if (state_reg == L_DONE) begin
                flash_reg.addr <= {addr_reg[23:1], la0_s};
                flash_reg.width_sel <= lx16_s;
            end else begin
                flash_reg.addr <= addr_reg;
                flash_reg.width_sel <= 1'b0;
            end
            flash_reg.ce_n <= ce_n_reg;
            flash_reg.oe_n <= oe_n_reg;
            flash_reg.we <= 1'b1;
            pin_drive_reg <= lprog_n_s;
            pullup_en_reg <= !lprog_n_s && !lpull_dis_s;
            busy_l_reg <= (state_reg != L_IDLE) && (state_reg != L_DONE);
            done_l_reg <= (state_reg == L_DONE);
        end
    end

    assign flash_o = flash_reg;
    assign init_status_n_o = 1'b0;
    // open drain: pulls low only, never while released
    assign init_status_oe_o = init_drive_reg && pin_drive_reg;
    assign chain_select_out_n_o = chain_sel_n_reg;
    assign config_clock_o = config_clock_reg;
    assign pin_drive_o = pin_drive_reg;
    assign pullup_en_o = pullup_en_reg;
    assign cfg_data_o = cfg_data_reg;
    assign cfg_valid_o = cfg_valid_reg;
    assign config_done_o = done_l_reg;
endmodule
`default_nettype wire

// ### include/pfcm_pkg.sv
/*
  Constants, registers, pin bundles and link states of the flash master.
  Assumes a 40 MHz clock and a separate link clock.
*/
package pfcm_pkg;
    localparam int CLK_MHZ = 40;
    localparam int INIT_TIME_US = 1000;
    localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OWN_LEN = 8'h04;
    localparam logic [7:0] REG_CHAIN_LEN = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_START_ADDR = 8'h10;

    localparam int CTRL_RELOAD_BIT = 0;
    localparam int CTRL_X16_BIT = 1;
    localparam int CTRL_USER_A0_BIT = 2;

    localparam int ST_INIT_DONE_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_LOADED_BIT = 2;
    localparam int ST_CHAIN_BIT = 3;
    localparam int ST_PROG_LOW_BIT = 4;
    localparam int ST_POR_OK_BIT = 5;

    localparam logic [23:0] OWN_LEN_RST = 24'h000400;
    localparam logic [23:0] CHAIN_LEN_RST = 24'h000000;
    localparam logic [23:0] START_ADDR_RST = 24'h000000;

    localparam logic [2:0] BOOT_PAR_UP = 3'h2;
    localparam logic [2:0] BOOT_PAR_DOWN = 3'h3;
    localparam logic [2:0] BOOT_SLAVE_PAR = 3'h6;
    localparam logic [2:0] BOOT_TEST_PORT = 3'h5;

    localparam logic [7:0] SPI_READ_CMD = 8'h03;
    localparam logic [5:0] SPI_FRAME_BITS = 6'h20;
    localparam logic [3:0] READ_WAIT_RST = 4'h8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic ce_n;
        logic oe_n;
        logic we;
        logic width_sel;
    } pfcm_flash_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } pfcm_spi_t;

    typedef enum logic [2:0] {
        L_IDLE,
        L_RELEASE,
        L_SPI,
        L_READ,
        L_CLK,
        L_DONE
    } pfcm_link_state_t;
endpackage
